//--- verilog/sfp_map.svh
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
// ****************************************************************
// widths and depths
// ****************************************************************
`define SFP_DATA_W     32
`define SFP_ADDR_W     5
`define SFP_ADDR_W_2B  2
`define SFP_FIFO_DEPTH 16
`define SFP_PART_LVL   8
`define SFP_SLOT_BIT   0
// ****************************************************************
// latencies in link clock cycles
// ****************************************************************
`define SFP_RD_LAT     2
`define SFP_FLAG_LAT   3
`define SFP_ADDR_LAT   3
`define SFP_SSD_MIN    2
`define SFP_SSD_MAX    68
// ****************************************************************
// clock figures
// ****************************************************************
`define SFP_CLK_NS     25
`define SFP_LINK_NS    200
`define SFP_LINK_DIV   (`SFP_LINK_NS / `SFP_CLK_NS)
`define SFP_DIV_MIN    8
`endif

//--- verilog/sfp_pkg.sv
`default_nettype none
package sfp_pkg;
   // meaning of a configurable flag output
   typedef enum logic [1:0] {
      sfp_flag_empty,
      sfp_flag_full,
      sfp_flag_partial
   } sfp_flag_mode_t;

   // commands accepted by the master end
   typedef enum logic [2:0] {
      sfp_cmd_write,
      sfp_cmd_write_last,
      sfp_cmd_read,
      sfp_cmd_zlp,
      sfp_cmd_switch
   } sfp_cmd_t;
endpackage
`default_nettype wire

//--- verilog/sfp_if.sv
`include "sfp_map.svh"
`default_nettype none
interface sfp_if #(
   parameter int DATA_W = `SFP_DATA_W,
   parameter int ADDR_W = `SFP_ADDR_W
) ();
   logic              pclk;
   logic              port_select_n;
   logic              bus_drive_enable_n;
   logic              read_strobe_n;
   logic              write_strobe_n;
   logic              packet_commit_n;
   logic              socket_change_n;
   logic [ADDR_W-1:0] slot_address;
   logic [DATA_W-1:0] host_dq;
   logic              host_dq_oe;
   logic [DATA_W-1:0] dev_dq;
   logic              dev_dq_oe;
   logic [DATA_W-1:0] dq;
   logic              flag_a;
   logic              flag_b;
   logic              slot_ready;

   // resolved data bus; an undriven bus reads as zero
   assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);

   modport dev (
      input  pclk, port_select_n, bus_drive_enable_n, read_strobe_n, write_strobe_n,
      input  packet_commit_n, socket_change_n, slot_address, dq,
      output dev_dq, dev_dq_oe, flag_a, flag_b, slot_ready
   );
   modport host (
      output pclk, port_select_n, bus_drive_enable_n, read_strobe_n, write_strobe_n,
      output packet_commit_n, socket_change_n, slot_address, host_dq, host_dq_oe,
      input  dq, dev_dq_oe, flag_a, flag_b, slot_ready
   );
endinterface
`default_nettype wire

//--- verilog/sfp_dev.sv
// Summary of operation
// - master holds address, select before reading
// - flag shows addressed FIFO not empty
// - output enable only gates bus drive
// - read strobe at edge advances read pointer
// - new data driven only with output enable
// - burst read yields a word per edge
// - early enable drives previously addressed data
// - flags configurable empty/full/partial, dedicated/current
// - socket switch strobe until slot ready
// - ready means can accept or supply
// - switch delay counted in link cycles
// - switch delay only in 5-bit variant
// - master drives data, address, select, write
// - write strobe stores word, advances pointer
// - flag updated fixed delay after write
// - burst write stores a word per edge
// - commit strobe with last word ends packet
// - master holds address during commit strobe
// - commit without write sends empty packet
// - read data two cycles after strobe
// - flags reflect write three cycles later
// - address change reflected three cycles later
`include "sfp_map.svh"
`default_nettype none
// ****************************************************************
// fifo between the link and the user side
// ****************************************************************
module sfp_fifo #(
   parameter int W     = `SFP_DATA_W,
   parameter int DEPTH = `SFP_FIFO_DEPTH
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst,
   input  wire logic [W-1:0]           i_data,
   input  wire logic                   i_valid,
   output logic                        o_ready,
   output logic [W-1:0]                o_data,
   output logic                        o_valid,
   input  wire logic                   i_ready,
   output logic [$clog2(DEPTH):0]      o_level
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } sfp_fifo_st_t;

   sfp_fifo_st_t st_r;
   sfp_fifo_st_t st_nxt;
   logic [W-1:0] mem [DEPTH];
   logic         push;
   logic         pop;

   // pointers wrap by overflow, so the depth must be a power of two
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sfp_fifo: DEPTH must be a power of two of at least 2");
   end

   // full and empty are taken from the registered count
   assign o_ready = st_r.cnt != (AW+1)'(DEPTH);
   assign o_valid = st_r.cnt != '0;
   assign o_data  = mem[st_r.rp];
   assign o_level = st_r.cnt;
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   // next pointer and count
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + AW'(1);
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + AW'(1);
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + (AW+1)'(1);
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - (AW+1)'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // storage holds no reset; only counted words are ever read
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[st_r.wp] <= i_data;
      end
   end
endmodule

// ****************************************************************
// device end of the slave fifo port
// ****************************************************************
module sfp_dev #(
   parameter int DATA_W     = `SFP_DATA_W,
   parameter int ADDR_W     = `SFP_ADDR_W,
   parameter int DEPTH      = `SFP_FIFO_DEPTH,
   parameter int PART_LVL   = `SFP_PART_LVL,
   parameter int SSD_CYCLES = `SFP_SSD_MIN
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst,
   sfp_if.dev                          lnk,
   output logic [DATA_W-1:0]           o_up_data,
   output logic                        o_up_last,
   output logic                        o_up_zlp,
   output logic                        o_up_valid,
   input  wire logic                   i_up_ready,
   input  wire logic [DATA_W-1:0]      i_dn_data,
   input  wire logic                   i_dn_valid,
   output logic                        o_dn_ready,
   input  wire sfp_pkg::sfp_flag_mode_t i_flag_a_mode,
   input  wire logic                   i_flag_a_current,
   input  wire logic                   i_flag_a_slot,
   input  wire sfp_pkg::sfp_flag_mode_t i_flag_b_mode,
   input  wire logic                   i_flag_b_current,
   input  wire logic                   i_flag_b_slot
);
   localparam int LW = $clog2(DEPTH) + 1;
   localparam int UW = DATA_W + 2;

   // pins as seen from the link, sampled as one vector
   typedef struct packed {
      logic              pclk;
      logic              sel_n;
      logic              oe_n;
      logic              rd_n;
      logic              wr_n;
      logic              pkt_n;
      logic              sw_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
   } sfp_pin_t;

   typedef struct packed {
      sfp_pin_t          s1;
      sfp_pin_t          s2;
      sfp_pin_t          s3;
      sfp_pin_t          ag;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dp0;
      logic [DATA_W-1:0] dp1;
      logic              fa0;
      logic              fa1;
      logic              fb0;
      logic              fb1;
      logic              oe;
      logic              pkt_prev;
      logic              sock;
      logic              switching;
      logic [7:0]        ssd;
      logic              rdy;
   } sfp_dev_st_t;

   // idle pin levels: strobes high, so no false request or drive follows reset
   localparam sfp_pin_t PIN_IDLE = '{pclk: 1'b0, sel_n: 1'b1, oe_n: 1'b1, rd_n: 1'b1,
      wr_n: 1'b1, pkt_n: 1'b1, sw_n: 1'b1, addr: '0, dq: '0};

   if (ADDR_W != `SFP_ADDR_W && ADDR_W != `SFP_ADDR_W_2B) begin
      $error("sfp_dev: ADDR_W must be the 2-bit or the 5-bit variant");
   end
   if (SSD_CYCLES < `SFP_SSD_MIN || SSD_CYCLES > `SFP_SSD_MAX) begin
      $error("sfp_dev: SSD_CYCLES out of range");
   end
   if (PART_LVL < 1 || PART_LVL > DEPTH) begin
      $error("sfp_dev: PART_LVL out of range");
   end

   sfp_dev_st_t    st_r;
   sfp_dev_st_t    st_nxt;
   sfp_pin_t       pin_in;
   sfp_pin_t       smp;
   logic           edge_seen;
   logic           sel, rd, wr, pkt, sw, prod;
   logic           up_in_valid;
   logic [UW-1:0]  up_in_data;
   logic [LW-1:0]  up_lvl;
   logic [LW-1:0]  dn_lvl;
   logic [DATA_W-1:0] dn_head;
   logic           dn_head_valid;
   logic           dn_pop;

   // a flag is high while its condition lets the master go on
   function automatic logic flag_eval(sfp_pkg::sfp_flag_mode_t m, logic [LW-1:0] lvl);
      case (m)
         sfp_pkg::sfp_flag_empty:   flag_eval = lvl != '0;
         sfp_pkg::sfp_flag_full:    flag_eval = lvl != LW'(DEPTH);
         sfp_pkg::sfp_flag_partial: flag_eval = lvl >= LW'(PART_LVL);
         default:                   flag_eval = 1'b0;
      endcase
   endfunction

   // level of the slot picked by its low address bit
   function automatic logic [LW-1:0] slot_lvl(logic slot, logic [LW-1:0] u, logic [LW-1:0] d);
      slot_lvl = slot ? d : u;
   endfunction

   // master-written words travel up, with packet marks beside them
   sfp_fifo #(.W(UW), .DEPTH(DEPTH)) u_up (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_data  (up_in_data),
      .i_valid (up_in_valid),
      .o_ready (),
      .o_data  ({o_up_zlp, o_up_last, o_up_data}),
      .o_valid (o_up_valid),
      .i_ready (i_up_ready),
      .o_level (up_lvl)
   );

   // user words travel down to the master; a full fifo stalls the user
   sfp_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_dn (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_data  (i_dn_data),
      .i_valid (i_dn_valid),
      .o_ready (o_dn_ready),
      .o_data  (dn_head),
      .o_valid (dn_head_valid),
      .i_ready (dn_pop),
      .o_level (dn_lvl)
   );

   assign pin_in = {lnk.pclk, lnk.port_select_n, lnk.bus_drive_enable_n, lnk.read_strobe_n,
                    lnk.write_strobe_n, lnk.packet_commit_n, lnk.socket_change_n,
                    lnk.slot_address, lnk.dq};

   // ****************************************************************
   // link sampling and decode
   // ****************************************************************
   // a bit is accepted once the second and third stages agree
   always_comb begin
      smp = sfp_pin_t'((~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.ag));
      edge_seen = smp.pclk && !st_r.ag.pclk;
      sel  = !smp.sel_n;
      rd   = sel && !smp.rd_n;
      wr   = sel && !smp.wr_n;
      pkt  = sel && !smp.pkt_n;
      sw   = sel && !smp.sw_n;
      prod = !smp.addr[`SFP_SLOT_BIT];
      dn_pop = edge_seen && rd && !prod;
      up_in_valid = 1'b0;
      up_in_data  = '0;
      if (edge_seen && wr && prod) begin
         up_in_valid = 1'b1;
         up_in_data  = {1'b0, pkt, smp.dq};
      end else if (edge_seen && pkt && !st_r.pkt_prev && prod) begin
         up_in_valid = 1'b1;
         up_in_data  = {1'b1, 1'b1, DATA_W'(0)};
      end
   end

   // ****************************************************************
   // state update
   // ****************************************************************
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.ag = smp;
      // drive follows the enable alone; no pointer or flag looks at it
      st_nxt.oe = !smp.oe_n;
      if (edge_seen) begin
         // head is peeked each edge, so an early enable shows the old head
         st_nxt.dp0 = dn_head_valid ? dn_head : st_r.dp0;
         st_nxt.dp1 = st_r.dp0;
         // flags use levels and address from before this edge
         st_nxt.fa0 = flag_eval(i_flag_a_mode, slot_lvl(i_flag_a_current ?
                      st_r.addr[`SFP_SLOT_BIT] : i_flag_a_slot, up_lvl, dn_lvl));
         st_nxt.fb0 = flag_eval(i_flag_b_mode, slot_lvl(i_flag_b_current ?
                      st_r.addr[`SFP_SLOT_BIT] : i_flag_b_slot, up_lvl, dn_lvl));
         st_nxt.fa1 = st_r.fa0;
         st_nxt.fb1 = st_r.fb0;
         st_nxt.addr = smp.addr;
         // a commit that rode on a write must not hide a following zlp
         st_nxt.pkt_prev = pkt && !wr;
         // socket switch: ready drops, then counts edges; the 2-bit variant follows the address with no drop
         if (ADDR_W == `SFP_ADDR_W_2B) begin
            st_nxt.sock = smp.addr[`SFP_SLOT_BIT];
            st_nxt.rdy  = smp.addr[`SFP_SLOT_BIT] ? dn_lvl != '0 : up_lvl != LW'(DEPTH);
         end else if (sw) begin
            st_nxt.sock      = smp.addr[`SFP_SLOT_BIT];
            st_nxt.switching = 1'b1;
            st_nxt.ssd       = 8'(SSD_CYCLES);
            st_nxt.rdy       = 1'b0;
         end else if (st_r.switching && st_r.ssd > 8'(1)) begin
            st_nxt.ssd = st_r.ssd - 8'(1);
         end else begin
            st_nxt.switching = 1'b0;
            // producer needs room, consumer needs data
            st_nxt.rdy = st_r.sock ? dn_lvl != '0 : up_lvl != LW'(DEPTH);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r    <= '0;
         st_r.s1 <= PIN_IDLE;
         st_r.s2 <= PIN_IDLE;
         st_r.s3 <= PIN_IDLE;
         st_r.ag <= PIN_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // link outputs, straight from the state
   // ****************************************************************
   assign lnk.dev_dq     = st_r.dp1;
   assign lnk.dev_dq_oe  = st_r.oe;
   assign lnk.flag_a     = st_r.fa1;
   assign lnk.flag_b     = st_r.fb1;
   assign lnk.slot_ready = st_r.rdy;
endmodule
`default_nettype wire

//--- verilog/sfp_host.sv
`include "sfp_map.svh"
`default_nettype none
// ****************************************************************
// master end: makes the link clock and drives the strobes
// ****************************************************************
module sfp_host #(
   parameter int DATA_W = `SFP_DATA_W,
   parameter int ADDR_W = `SFP_ADDR_W,
   parameter int DIV    = `SFP_LINK_DIV,
   parameter int RD_LAT = `SFP_RD_LAT
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst,
   sfp_if.host                         lnk,
   input  wire logic                   i_cmd_valid,
   input  wire sfp_pkg::sfp_cmd_t      i_cmd,
   input  wire logic [ADDR_W-1:0]      i_cmd_addr,
   input  wire logic [DATA_W-1:0]      i_cmd_data,
   output logic                        o_cmd_ready,
   output logic [DATA_W-1:0]           o_rd_data,
   output logic                        o_rd_valid,
   output logic                        o_flag_a,
   output logic                        o_flag_b,
   output logic                        o_slot_ready
);
   localparam int CW   = $clog2(DIV);
   localparam int HALF = DIV / 2;

   typedef struct packed {
      logic [DATA_W-1:0] dq;
      logic              fa;
      logic              fb;
      logic              rdy;
   } sfp_hin_t;

   typedef struct packed {
      logic [CW-1:0]     cnt;
      logic              pclk;
      logic              ready;
      logic              sel_n;
      logic              oe_n;
      logic              rd_n;
      logic              wr_n;
      logic              pkt_n;
      logic              sw_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic              dq_oe;
      logic [RD_LAT:0]   rdp;
      sfp_hin_t          s1;
      sfp_hin_t          s2;
      sfp_hin_t          s3;
      sfp_hin_t          ag;
      logic [DATA_W-1:0] rd_data;
      logic              rd_valid;
   } sfp_host_st_t;

   // the device needs several of its clocks per link half period
   if (DIV < `SFP_DIV_MIN || DIV % 2 != 0) begin
      $error("sfp_host: DIV must be even and at least the minimum");
   end
   if (RD_LAT < 1) begin
      $error("sfp_host: RD_LAT must be at least 1");
   end

   sfp_host_st_t st_r;
   sfp_host_st_t st_nxt;
   sfp_hin_t     hin;
   logic [CW-1:0] cnt_nxt;
   logic          rise;

   assign hin = {lnk.dq, lnk.flag_a, lnk.flag_b, lnk.slot_ready};

   // ****************************************************************
   // clock divider, command issue and read capture
   // ****************************************************************
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = hin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.ag = sfp_hin_t'((~(st_r.s2 ^ st_r.s3) & st_r.s3) |
                             ((st_r.s2 ^ st_r.s3) & st_r.ag));
      st_nxt.rd_valid = 1'b0;
      cnt_nxt = (st_r.cnt == CW'(DIV - 1)) ? '0 : st_r.cnt + CW'(1);
      rise    = st_r.cnt == CW'(DIV - 1);
      st_nxt.cnt   = cnt_nxt;
      st_nxt.pclk  = cnt_nxt < CW'(HALF);
      st_nxt.ready = cnt_nxt == CW'(HALF - 1);
      // data is taken from this cycle's agreed sample; ag would be a cycle late
      if (rise) begin
         if (st_r.rdp[RD_LAT]) begin
            st_nxt.rd_data  = st_nxt.ag.dq;
            st_nxt.rd_valid = 1'b1;
         end
         st_nxt.rdp = {st_r.rdp[RD_LAT-1:0], 1'b0};
      end
      // pins change only at the falling link edge, away from sampling
      if (st_r.ready) begin
         st_nxt.rd_n  = 1'b1;
         st_nxt.wr_n  = 1'b1;
         st_nxt.pkt_n = 1'b1;
         st_nxt.sw_n  = 1'b1;
         st_nxt.dq_oe = 1'b0;
         // select and enable stay low while read words are still due
         st_nxt.sel_n = st_r.rdp == '0;
         st_nxt.oe_n  = st_r.rdp == '0;
         if (i_cmd_valid) begin
            st_nxt.sel_n = 1'b0;
            st_nxt.addr  = i_cmd_addr;
            case (i_cmd)
               sfp_pkg::sfp_cmd_write: begin
                  st_nxt.wr_n  = 1'b0;
                  st_nxt.dq    = i_cmd_data;
                  st_nxt.dq_oe = 1'b1;
                  st_nxt.oe_n  = 1'b1;
               end
               sfp_pkg::sfp_cmd_write_last: begin
                  st_nxt.wr_n  = 1'b0;
                  st_nxt.pkt_n = 1'b0;
                  st_nxt.dq    = i_cmd_data;
                  st_nxt.dq_oe = 1'b1;
                  st_nxt.oe_n  = 1'b1;
               end
               sfp_pkg::sfp_cmd_read: begin
                  st_nxt.rd_n   = 1'b0;
                  st_nxt.oe_n   = 1'b0;
                  st_nxt.rdp[0] = 1'b1;
               end
               sfp_pkg::sfp_cmd_zlp: begin
                  st_nxt.pkt_n = 1'b0;
               end
               sfp_pkg::sfp_cmd_switch: begin
                  st_nxt.sw_n = 1'b0;
               end
               default: begin
                  st_nxt.sel_n = 1'b1;
               end
            endcase
         end
      end
   end

   // strobes idle high after reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r       <= '0;
         st_r.sel_n <= 1'b1;
         st_r.oe_n  <= 1'b1;
         st_r.rd_n  <= 1'b1;
         st_r.wr_n  <= 1'b1;
         st_r.pkt_n <= 1'b1;
         st_r.sw_n  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign lnk.pclk               = st_r.pclk;
   assign lnk.port_select_n      = st_r.sel_n;
   assign lnk.bus_drive_enable_n = st_r.oe_n;
   assign lnk.read_strobe_n      = st_r.rd_n;
   assign lnk.write_strobe_n     = st_r.wr_n;
   assign lnk.packet_commit_n    = st_r.pkt_n;
   assign lnk.socket_change_n    = st_r.sw_n;
   assign lnk.slot_address       = st_r.addr;
   assign lnk.host_dq            = st_r.dq;
   assign lnk.host_dq_oe         = st_r.dq_oe;
   assign o_cmd_ready            = st_r.ready;
   assign o_rd_data              = st_r.rd_data;
   assign o_rd_valid             = st_r.rd_valid;
   assign o_flag_a               = st_r.ag.fa;
   assign o_flag_b               = st_r.ag.fb;
   assign o_slot_ready           = st_r.ag.rdy;
endmodule
`default_nettype wire

//--- verification/sfp_assertions.sv
`default_nettype none
// ********************
// link wire checks
// ********************
module sfp_assertions (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       pclk,
   input wire logic       port_select_n,
   input wire logic       bus_drive_enable_n,
   input wire logic       read_strobe_n,
   input wire logic       write_strobe_n,
   input wire logic       packet_commit_n,
   input wire logic       socket_change_n,
   input wire logic [4:0] slot_address,
   input wire logic       host_dq_oe,
   input wire logic       dev_dq_oe,
   input wire logic       flag_a,
   input wire logic       flag_b,
   input wire logic       slot_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // host framing: strobes move away from the sampling edge
   link_clock_a: assert property ($fell(pclk) |-> !pclk[*4] ##1 pclk[*4] ##1 !pclk)
      else $error("link clock half period wrong");
   strobe_edge_a: assert property ($changed({read_strobe_n, write_strobe_n, packet_commit_n})
      |-> !pclk) else $error("strobe moved with link clock high");
   select_gate_a: assert property (!(read_strobe_n && write_strobe_n && packet_commit_n)
      |-> !port_select_n) else $error("strobe without select");
   addr_hold_a: assert property ((!packet_commit_n && !$past(packet_commit_n))
      || (!read_strobe_n && !$past(read_strobe_n)) |-> $stable(slot_address))
      else $error("address moved under a held strobe");
   // bus ownership: only one end may drive, and the device only when enabled
   bus_owner_a: assert property (!(dev_dq_oe && host_dq_oe))
      else $error("both ends drive the bus");
   oe_follow_a: assert property ($changed(bus_drive_enable_n)
      |-> ##[1:8] (dev_dq_oe == !bus_drive_enable_n)) else $error("bus drive did not follow");
   // switching: ready drops, stays low for the delay, then returns
   switch_delay_a: assert property (($fell(socket_change_n) && !port_select_n)
      ##[1:12] $fell(slot_ready) |-> !slot_ready[*8] ##1 !slot_ready[*7])
      else $error("slot ready back too early");
   switch_ready_a: assert property (($fell(socket_change_n) && !port_select_n)
      |-> ##[16:32] slot_ready) else $error("slot ready missing after switch");
   reset_idle_a: assert property ($fell(i_rst) |-> !dev_dq_oe && !slot_ready && !flag_a
      && !flag_b && !host_dq_oe && !pclk) else $error("outputs not idle after reset");
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`default_nettype none
// ********************
// both ends back to back
// ********************
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_clk = 0, i_rst = 1, i_cmd_valid = 0, i_up_ready = 0, i_dn_valid = 0;
   logic [31:0] i_cmd_data = 0, i_dn_data = 0, o_rd_data, o_up_data, w;
   logic [4:0]  i_cmd_addr = 0;
   logic        o_cmd_ready, o_rd_valid, o_flag_a, o_flag_b, o_slot_ready;
   logic        o_up_last, o_up_zlp, o_up_valid, o_dn_ready;
   logic        i_flag_a_current = 1, i_flag_a_slot = 1, i_flag_b_current = 0, i_flag_b_slot = 0;
   sfp_pkg::sfp_cmd_t       i_cmd = sfp_pkg::sfp_cmd_write;
   sfp_pkg::sfp_flag_mode_t i_flag_a_mode = sfp_pkg::sfp_flag_empty;
   sfp_pkg::sfp_flag_mode_t i_flag_b_mode = sfp_pkg::sfp_flag_partial;
   int          seed = 32'h0a89_706b, n_mismatch = 0, num_checks = 0, k;
   logic [33:0] up_q[$];
   logic [33:0] rd_q[$];
   sfp_if lnk ();
   sfp_host sfp_host_i (.i_clk, .i_rst, .lnk, .i_cmd_valid, .i_cmd, .i_cmd_addr, .i_cmd_data,
      .o_cmd_ready, .o_rd_data, .o_rd_valid, .o_flag_a, .o_flag_b, .o_slot_ready);
   sfp_dev sfp_dev_i (.i_clk, .i_rst, .lnk, .o_up_data, .o_up_last, .o_up_zlp, .o_up_valid,
      .i_up_ready, .i_dn_data, .i_dn_valid, .o_dn_ready, .i_flag_a_mode, .i_flag_a_current,
      .i_flag_a_slot, .i_flag_b_mode, .i_flag_b_current, .i_flag_b_slot);
   sfp_assertions sfp_assertions_i (.i_clk, .i_rst, .pclk(lnk.pclk),
      .port_select_n(lnk.port_select_n), .bus_drive_enable_n(lnk.bus_drive_enable_n),
      .read_strobe_n(lnk.read_strobe_n), .write_strobe_n(lnk.write_strobe_n),
      .packet_commit_n(lnk.packet_commit_n), .socket_change_n(lnk.socket_change_n),
      .slot_address(lnk.slot_address), .host_dq_oe(lnk.host_dq_oe), .dev_dq_oe(lnk.dev_dq_oe),
      .flag_a(lnk.flag_a), .flag_b(lnk.flag_b), .slot_ready(lnk.slot_ready));
   // 40 MHz system clock
   always #12.5 i_clk = ~i_clk;
   task automatic chk(logic [33:0] got, logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // valid stays up after acceptance; ready is a pulse, so a stale command is never retaken
   task automatic cmd(sfp_pkg::sfp_cmd_t c, logic [4:0] a, logic [31:0] d);
      i_cmd_valid = 1;
      i_cmd = c;
      i_cmd_addr = a;
      i_cmd_data = d;
      do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
      #1;
   endtask
   function automatic logic [33:0] up_e(logic z, logic l, logic [31:0] d);
      return {z, l, z ? 32'h0000_0000 : d};
   endfunction
   task automatic drain;
      i_up_ready = 1;
      for (k = 0; k < 400 && up_q.size() > 0; k++) begin
         @(posedge i_clk);
         if (o_up_valid === 1'b1) chk({o_up_zlp, o_up_last, o_up_data}, up_q.pop_front());
      end
      #1 chk({33'h0, o_up_valid}, 34'h0);
      i_up_ready = 0;
   endtask
   // read words come back on their own; order must match the down buffer
   always @(posedge i_clk)
      if (o_rd_valid === 1'b1) chk({2'b00, o_rd_data}, rd_q.pop_front());
   initial begin
      repeat (10) @(posedge i_clk);
      #1 i_rst = 0;
      // overfill the up buffer with the user side stalled: two words must vanish
      cmd(sfp_pkg::sfp_cmd_switch, 5'h00, 0);
      for (int i = 0; i < 18; i++) begin
         w = $random(seed);
         cmd(i == 17 ? sfp_pkg::sfp_cmd_write_last : sfp_pkg::sfp_cmd_write, 5'h00, w);
         if (i < 16) up_q.push_back(up_e(0, 0, w));
      end
      i_cmd_valid = 0;
      repeat (48) @(posedge i_clk);
      #1 chk({32'h0, o_flag_a, o_flag_b}, 34'h3);
      // same fill seen through a full-mode flag: no room left
      i_flag_b_mode = sfp_pkg::sfp_flag_full;
      repeat (24) @(posedge i_clk);
      #1 chk({32'h0, o_flag_a, o_flag_b}, 34'h2);
      i_flag_b_mode = sfp_pkg::sfp_flag_partial;
      drain;
      repeat (48) @(posedge i_clk);
      #1 chk({32'h0, o_flag_a, o_flag_b}, 34'h0);
      // short packet followed by an empty one
      w = $random(seed);
      cmd(sfp_pkg::sfp_cmd_write_last, 5'h00, w);
      up_q.push_back(up_e(0, 1, w));
      cmd(sfp_pkg::sfp_cmd_zlp, 5'h00, 0);
      up_q.push_back(up_e(1, 1, 0));
      i_cmd_valid = 0;
      repeat (40) @(posedge i_clk);
      #1 drain;
      // fill the down buffer until it refuses
      i_dn_valid = 1;
      for (int i = 0; i < 20; i++) begin
         i_dn_data = $random(seed);
         @(posedge i_clk);
         if (o_dn_ready === 1'b1) rd_q.push_back({2'b00, i_dn_data});
         #1;
      end
      i_dn_valid = 0;
      cmd(sfp_pkg::sfp_cmd_switch, 5'h01, 0);
      i_cmd_valid = 0;
      repeat (48) @(posedge i_clk);
      #1 chk({32'h0, o_flag_a, o_slot_ready}, 34'h3);
      // one unbroken burst empties it
      for (int i = 0; i < 16; i++) cmd(sfp_pkg::sfp_cmd_read, 5'h01, 0);
      i_cmd_valid = 0;
      repeat (48) @(posedge i_clk);
      chk(34'(rd_q.size()), 34'h0);
      wrap_up;
   end
   // a hang counts as a failure
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      wrap_up;
   end
endmodule
`default_nettype wire
